// [hptx_host_port_tx_control.sv]
// Purpose: Host port transmit control with global soft reset, AXI4-Lite regs.
// Assumes: Host queue delivers one byte per beat, frame id held on every beat.
// Notes:   Output passes through a two-entry buffer; stalls lose no byte.
// Operation
// - Register bit 0 of the soft reset register holds soft reset active while one.
// - Soft reset clears the transmit logic and switch settings but not the bus slave.
// - With pause generation enabled a pause frame goes out when the RX FIFO hits threshold.
// - Pause generation also needs the switch global pause bit to be set.
// - With padding enabled frames shorter than 64 bytes are padded to minimum length.
// - With CRC enabled a CRC is computed and appended to each frame.
// - Run enable starts transmission; clearing it stops after the current frame.
// - The status register shows in bits 5-0 the id of the last sent host frame; pause frames leave it unchanged.
`include "hptx_regs.svh"

module hptx_host_port_tx_control #(
   parameter int          DEPTH       = 2,
   parameter logic [47:0] PAUSE_SRC   = 48'h0000_0000_0001,
   parameter logic [15:0] PAUSE_QUANT = 16'hFFFF
) (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic [7:0]         s_data,
   input  wire logic               s_last,
   input  wire logic [5:0]         s_fid,
   input  wire logic               s_valid,
   output logic                    s_ready,
   input  wire logic               rx_fifo_at_threshold,
   output logic [7:0]              m_data,
   output logic                    m_last,
   output logic                    m_valid,
   input  wire logic               m_ready,
   output logic                    soft_reset_active
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam int PW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_depth_check
      $error("DEPTH must be a power of two of at least two.");
   end

   logic [15:0]             tx_control;
   logic [15:0]             tx_status;
   logic [15:0]             soft_reset_reg;
   logic [15:0]             sw_global3;
   logic                    rst_all;
   logic                    aw_held;
   logic                    w_held;
   logic [7:0]              aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    do_write;
   logic [15:0]             wmask;
   logic [15:0]             wval;
   hptx_pkg::hptx_state_e   state;
   hptx_pkg::hptx_state_e   next_state;
   hptx_pkg::hptx_beat_s    beat;
   logic                    beat_valid;
   logic [6:0]              cnt;
   logic [31:0]             crc;
   logic [1:0]              crc_idx;
   logic [5:0]              cur_fid;
   logic                    thr_prev;
   logic                    pause_pending;
   logic                    pause_ok;
   logic                    emit;
   logic [6:0]              pad_target;
   hptx_pkg::hptx_beat_s    mem [DEPTH];
   logic [PW-1:0]           wr_ptr;
   logic [PW-1:0]           rd_ptr;
   logic [PW:0]             fill;
   logic                    buf_ready;
   logic                    buf_pop;
   logic                    in_pause;

   // Soft reset covers everything except the bus slave handshake.
   assign soft_reset_active = soft_reset_reg[`HPTX_BIT_SOFT_RESET];
   assign rst_all           = srst | soft_reset_active;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // Reflected CRC-32 update by one byte.
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h00_0000, b};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ `HPTX_CRC_POLY) : (r >> 1);
      return r;
   endfunction

   // Pause frame header byte at a given position, zero beyond it.
   function automatic logic [7:0] pause_byte(input logic [6:0] idx);
      logic [159:0] hdr;
      hdr = {`HPTX_PAUSE_DA, PAUSE_SRC, `HPTX_PAUSE_TYPE, `HPTX_PAUSE_OPCODE,
             PAUSE_QUANT, 16'h0000};
      hdr = hdr << {idx, 3'b000};
      return hdr[159:152];
   endfunction

   // Index of a word address; all ones when misaligned.
   function automatic logic [5:0] reg_index(input logic [7:0] a);
      return (a[1:0] == 2'b00) ? a[7:2] : 6'h3F;
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;
   assign wmask         = {{8{w_strb[1]}}, {8{w_strb[0]}}};

   // Address and data are captured in either order.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   // Write response, error for an unmapped or read-only word.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `HPTX_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         case (reg_index(aw_addr))
            `HPTX_IDX_TX_CONTROL,
            `HPTX_IDX_SOFT_RESET,
            `HPTX_IDX_SW_GLOBAL3: s_axi_bresp <= `HPTX_RESP_OKAY;
            default:              s_axi_bresp <= `HPTX_RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Soft reset register, cleared only by the hardware reset.
   always_ff @(posedge clk)
   begin
      if (srst)
         soft_reset_reg <= `HPTX_REG_RESET;
      else if (do_write && reg_index(aw_addr) == `HPTX_IDX_SOFT_RESET && w_strb[0])
         soft_reset_reg[`HPTX_BIT_SOFT_RESET] <= w_data[`HPTX_BIT_SOFT_RESET];
   end

   // Control and switch settings, both cleared by soft reset.
   assign wval = w_data[15:0];
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         tx_control <= `HPTX_REG_RESET;
         sw_global3 <= `HPTX_REG_RESET;
      end
      else if (do_write)
      begin
         if (reg_index(aw_addr) == `HPTX_IDX_TX_CONTROL)
            tx_control <= (tx_control & ~(wmask & `HPTX_CTRL_RW_MASK))
                        | (wval & wmask & `HPTX_CTRL_RW_MASK);
         if (reg_index(aw_addr) == `HPTX_IDX_SW_GLOBAL3)
            sw_global3 <= (sw_global3 & ~(wmask & `HPTX_SW3_RW_MASK))
                        | (wval & wmask & `HPTX_SW3_RW_MASK);
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   // Read data registered one cycle after the address is taken.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `HPTX_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `HPTX_RESP_OKAY;
         case (reg_index(s_axi_araddr))
            `HPTX_IDX_TX_CONTROL: s_axi_rdata <= {16'h0000, tx_control};
            `HPTX_IDX_TX_STATUS:  s_axi_rdata <= {16'h0000, tx_status};
            `HPTX_IDX_SOFT_RESET: s_axi_rdata <= {16'h0000, soft_reset_reg};
            `HPTX_IDX_SW_GLOBAL3: s_axi_rdata <= {16'h0000, sw_global3};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `HPTX_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ------------------------------------------------------------
   // Pause request tracking
   // ------------------------------------------------------------
   assign pause_ok = tx_control[`HPTX_BIT_PAUSE]
                   & sw_global3[`HPTX_BIT_SW_PAUSE];

   // A rising threshold arms one pause frame; arming wins over the take.
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         thr_prev      <= 1'b0;
         pause_pending <= 1'b0;
      end
      else
      begin
         thr_prev <= rx_fifo_at_threshold;
         if (!pause_ok)
            pause_pending <= 1'b0;
         else if (rx_fifo_at_threshold && !thr_prev)
            pause_pending <= 1'b1;
         else if (state == hptx_pkg::HPTX_IDLE)
            pause_pending <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Transmit sequencer
   // ------------------------------------------------------------
   assign pad_target = tx_control[`HPTX_BIT_CRC] ? (`HPTX_MIN_FRAME - `HPTX_CRC_BYTES)
                                                 : `HPTX_MIN_FRAME;
   assign s_ready    = (state == hptx_pkg::HPTX_DATA) && buf_ready && !soft_reset_active;
   assign emit       = beat_valid && buf_ready;

   // Next byte and next state.
   always_comb
   begin
      next_state = state;
      beat_valid = 1'b0;
      beat       = '{data: 8'h00, last: 1'b0, fid: cur_fid, host: 1'b1};
      case (state)
         hptx_pkg::HPTX_IDLE:
         begin
            if (pause_pending)
               next_state = hptx_pkg::HPTX_PAUSE;
            else if (tx_control[`HPTX_BIT_RUN] && s_valid)
               next_state = hptx_pkg::HPTX_DATA;
         end
         hptx_pkg::HPTX_DATA:
         begin
            beat_valid = s_valid;
            beat.data  = s_data;
            beat.fid   = s_fid;
            if (s_valid && buf_ready && s_last)
            begin
               if (tx_control[`HPTX_BIT_PAD] && (cnt + 7'h01) < pad_target)
                  next_state = hptx_pkg::HPTX_PAD;
               else if (tx_control[`HPTX_BIT_CRC])
                  next_state = hptx_pkg::HPTX_CRC;
               else
               begin
                  beat.last  = 1'b1;
                  next_state = hptx_pkg::HPTX_IDLE;
               end
            end
         end
         hptx_pkg::HPTX_PAD:
         begin
            beat_valid = 1'b1;
            if (buf_ready && (cnt + 7'h01) >= pad_target)
            begin
               if (tx_control[`HPTX_BIT_CRC])
                  next_state = hptx_pkg::HPTX_CRC;
               else
               begin
                  beat.last  = 1'b1;
                  next_state = hptx_pkg::HPTX_IDLE;
               end
            end
         end
         hptx_pkg::HPTX_PAUSE:
         begin
            beat_valid = 1'b1;
            beat.host  = 1'b0;
            beat.data  = pause_byte(cnt);
            if (buf_ready && (cnt + 7'h01) == (`HPTX_MIN_FRAME - `HPTX_CRC_BYTES))
               next_state = hptx_pkg::HPTX_CRC;
         end
         hptx_pkg::HPTX_CRC:
         begin
            beat_valid = 1'b1;
            beat.host  = !in_pause;
            beat.data  = ~crc[{crc_idx, 3'b000} +: 8];
            beat.last  = (crc_idx == `HPTX_CRC_LAST);
            if (buf_ready && beat.last)
               next_state = hptx_pkg::HPTX_IDLE;
         end
         default: next_state = hptx_pkg::HPTX_IDLE;
      endcase
   end

   // State and frame bookkeeping; run enable is only looked at in idle.
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         state    <= hptx_pkg::HPTX_IDLE;
         cnt      <= 7'h00;
         crc      <= `HPTX_CRC_INIT;
         crc_idx  <= 2'h0;
         cur_fid  <= 6'h00;
         in_pause <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == hptx_pkg::HPTX_IDLE)
         begin
            cnt      <= 7'h00;
            crc      <= `HPTX_CRC_INIT;
            crc_idx  <= 2'h0;
            in_pause <= (next_state == hptx_pkg::HPTX_PAUSE);
         end
         else if (emit && state == hptx_pkg::HPTX_CRC)
            crc_idx <= crc_idx + 2'h1;
         else if (emit)
         begin
            cnt <= cnt + {6'h00, ~&cnt[6:1]}; // Stops below wrap so long frames never pad.
            crc <= crc_step(crc, beat.data);
         end
         if (state == hptx_pkg::HPTX_DATA && s_valid && s_ready)
            cur_fid <= s_fid;
      end
   end

   // ------------------------------------------------------------
   // Output buffer
   // ------------------------------------------------------------
   assign buf_ready = (fill < (PW + 1)'(DEPTH));
   assign m_valid   = (fill != '0);
   assign buf_pop   = m_valid && m_ready;
   assign m_data    = mem[rd_ptr].data;
   assign m_last    = mem[rd_ptr].last;

   // Entry storage, one generate slot per entry.
   for (genvar g = 0; g < DEPTH; g++)
   begin : g_entry
      always_ff @(posedge clk)
      begin
         if (rst_all)
            mem[g] <= '0;
         else if (emit && wr_ptr == PW'(g))
            mem[g] <= beat;
      end
   end

   // Pointers and fill level.
   always_ff @(posedge clk)
   begin
      if (rst_all)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end
      else
      begin
         if (emit)
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
         if (buf_pop)
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
         fill <= fill + (PW + 1)'(emit) - (PW + 1)'(buf_pop);
      end
   end

   // Status records the id of each host frame as its last byte leaves.
   always_ff @(posedge clk)
   begin
      if (rst_all)
         tx_status <= `HPTX_REG_RESET;
      else if (buf_pop && mem[rd_ptr].last && mem[rd_ptr].host)
         tx_status <= {10'h000, mem[rd_ptr].fid};
   end

endmodule // hptx_host_port_tx_control

// [hptx_pkg.sv]
// Purpose: Types shared by the host port transmit control block.
// Assumes: Constants live in hptx_regs.svh.
// Notes:   States are one-hot.
package hptx_pkg;

   // Transmit sequencer states.
   typedef enum logic [4:0] {
      HPTX_IDLE  = 5'h01,
      HPTX_DATA  = 5'h02,
      HPTX_PAD   = 5'h04,
      HPTX_PAUSE = 5'h08,
      HPTX_CRC   = 5'h10
   } hptx_state_e;

   // One byte of an outgoing frame with its tags.
   typedef struct packed {
      logic [7:0] data;
      logic       last;
      logic [5:0] fid;
      logic       host;
   } hptx_beat_s;

endpackage

// [hptx_props.sv]
// Purpose: Port checks for the host port transmit control block.
// Assumes: Bound to the top module by the bench.
// Notes:   One clock domain; srst disables all but the reset check.
module hptx_props (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        s_ready,
   input wire logic [7:0]  m_data,
   input wire logic        m_last,
   input wire logic        m_valid,
   input wire logic        m_ready,
   input wire logic        soft_reset_active
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Responses and output bytes stay put until they are taken.
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response withdrawn");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read response changed");
   out_hold_a: assert property (m_valid && !m_ready && !soft_reset_active |=> m_valid
      && $stable({m_data, m_last})) else $error("output byte changed while stalled");
   // Answer timing follows the hand-over figures.
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   // Soft reset holds the datapath idle and empties the buffer.
   soft_idle_a: assert property (soft_reset_active |-> !s_ready)
      else $error("input accepted in soft reset");
   soft_flush_a: assert property (soft_reset_active [*2] |-> !m_valid)
      else $error("output busy in soft reset");
   reset_clear_a: assert property (disable iff (1'b0) srst |=> !m_valid
      && !s_axi_bvalid && !s_axi_rvalid && !soft_reset_active) else $error("reset not clean");
   frame_end_c: cover property (m_valid && m_ready && m_last);
   soft_on_c: cover property ($rose(soft_reset_active));
   slverr_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // hptx_props

// [hptx_regs.svh]
// Purpose: Register indices, field positions and framing constants.
// Assumes: Included by the transmit control top module.
// Notes:   Byte address of a register is four times its index.
`ifndef HPTX_REGS_SVH
`define HPTX_REGS_SVH
`define HPTX_IDX_TX_CONTROL  6'h00
`define HPTX_IDX_TX_STATUS   6'h02
`define HPTX_IDX_SOFT_RESET  6'h06
`define HPTX_IDX_SW_GLOBAL3  6'h10
`define HPTX_BIT_RUN         0
`define HPTX_BIT_CRC         1
`define HPTX_BIT_PAD         2
`define HPTX_BIT_PAUSE       3
`define HPTX_CTRL_RW_MASK    16'h600F
`define HPTX_BIT_SOFT_RESET  0
`define HPTX_BIT_SW_PAUSE    5
`define HPTX_SW3_RW_MASK     16'h0020
`define HPTX_REG_RESET       16'h0000
`define HPTX_MIN_FRAME       7'h40
`define HPTX_CRC_BYTES       7'h04
`define HPTX_CRC_LAST        2'h3
`define HPTX_CRC_POLY        32'hEDB8_8320
`define HPTX_CRC_INIT        32'hFFFF_FFFF
`define HPTX_PAUSE_DA        48'h0180_C200_0001
`define HPTX_PAUSE_TYPE      16'h8808
`define HPTX_PAUSE_OPCODE    16'h0001
`define HPTX_RESP_OKAY       2'h0
`define HPTX_RESP_SLVERR     2'h2
`endif

// [hptx_sink.sv]
// Purpose: Receiver on the transmit byte stream that records each frame.
// Assumes: Byte taken at a rising edge where m_valid and m_ready are high.
// Notes:   The last four bytes of a frame are kept, first byte lowest.
module hptx_sink (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [7:0]  m_data,
   input  wire logic        m_last,
   input  wire logic        m_valid,
   output logic             m_ready,
   input  wire logic        hold,
   input  wire logic        slow,
   output logic [7:0]       frames,
   output logic [7:0]       len,
   output logic [7:0]       first,
   output logic [31:0]      fcs
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cnt;
   // Ready is held low on request and toggles when slow, to stall the buffer.
   always_ff @(posedge clk)
      m_ready <= !srst && !hold && (!slow || !m_ready);
   // Counts bytes of a frame and latches its length and tail.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt <= 8'h00;
         frames <= 8'h00;
      end
      else if (m_valid && m_ready)
      begin
         cnt <= m_last ? 8'h00 : cnt + 8'h01;
         fcs <= {m_data, fcs[31:8]};
         if (cnt == 8'h00) first <= m_data;
         if (m_last) len <= cnt + 8'h01;
         if (m_last) frames <= frames + 8'h01;
      end
   end
endmodule // hptx_sink

// [test_host_port_tx_control.sv]
// Purpose: Self-checking bench for the host port transmit control block.
// Assumes: Sink model on the byte output; AXI4-Lite master tasks below.
// Notes:   Register byte address is four times the register index.
`include "hptx_regs.svh"
module test_host_port_tx_control;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [1:0] okr = `HPTX_RESP_OKAY;
   localparam logic [1:0] err = `HPTX_RESP_SLVERR;
   logic clk = 0, srst = 1, hold = 0, slow = 0, thr = 0, s_valid = 0, s_last = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, s_ready, m_last, m_valid, m_ready, soft_reset_active;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_data = '0;
   logic [7:0]  m_data, frames, len, first;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, fcs;
   logic [3:0]  s_axi_wstrb = 4'h3;
   logic [5:0]  s_fid = '0;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          error_cnt = 0, compares = 0, taken = 0, cyc = 0;
   hptx_host_port_tx_control DUT (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_data, .s_last, .s_fid, .s_valid,
      .s_ready, .rx_fifo_at_threshold(thr), .m_data, .m_last, .m_valid, .m_ready,
      .soft_reset_active);
   hptx_sink sink (.clk, .srst, .m_data, .m_last, .m_valid, .m_ready, .hold, .slow,
      .frames, .len, .first, .fcs);
   // Free-running clock at 20 MHz.
   initial
   begin
      forever #25 clk = ~clk;
   end
   // Cuts a hung run short.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000) begin error_cnt++; complete_run(); end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Expected check sequence over n pattern bytes then zero fill to tot bytes.
   function automatic logic [31:0] crc(input int n, input logic [5:0] f, input int tot);
      logic [31:0] c;
      c = `HPTX_CRC_INIT;
      for (int i = 0; i < tot; i++)
      begin
         c ^= {24'h00_0000, (i < n) ? {2'b00, f} + 8'(i) : 8'h00};
         for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ `HPTX_CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      bit ak, rk;
      logic [31:0] d;
      logic [1:0] r;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      for (int t = 0; t < 100 && !rk; t++)
      begin
         @(negedge clk);
         ak = s_axi_arready; rk = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp;
         @(posedge clk);
         if (ak) s_axi_arvalid <= 1'b0;
      end
      chk(d, e, "read data");
      chk({30'h0, r}, {30'h0, er}, "read response");
   endtask
   task automatic wc(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
      bit ak, wk, bk;
      logic [1:0] r;
      s_axi_awaddr <= a; s_axi_wdata <= {16'h0000, v};
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      for (int t = 0; t < 100 && !bk; t++)
      begin
         @(negedge clk);
         ak = s_axi_awready; wk = s_axi_wready; bk = s_axi_bvalid; r = s_axi_bresp;
         @(posedge clk);
         if (ak) s_axi_awvalid <= 1'b0;
         if (wk) s_axi_wvalid <= 1'b0;
      end
      chk({30'h0, r}, {30'h0, er}, "write response");
   endtask
   // Host queue frame: byte i is fid plus i, fid on every beat.
   task automatic send(input int n, input logic [5:0] f);
      bit k;
      for (int i = 0; i < n; i++)
      begin
         s_data <= {2'b00, f} + 8'(i); s_last <= (i == n - 1); s_fid <= f; s_valid <= 1'b1;
         k = 0;
         for (int t = 0; t < 300 && !k; t++)
         begin
            @(negedge clk);
            k = s_ready;
            @(posedge clk);
         end
         taken++;
      end
      s_valid <= 1'b0;
   endtask
   task automatic wf(input logic [7:0] n);
      for (int t = 0; t < 3000 && frames !== n; t++) @(posedge clk);
      chk(frames, n, "frame count");
   endtask
   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rc(8'h00, 32'h0000_0000, okr);
      rc(8'h08, 32'h0000_0000, okr);
      rc(8'h18, 32'h0000_0000, okr);
      rc(8'h04, 32'h0000_0000, err);
      wc(8'h08, 16'h003F, err);
      wc(8'h00, 16'hFFFF, okr);
      rc(8'h00, {16'h0000, `HPTX_CTRL_RW_MASK}, okr);
      $display("test registers done");
      wc(8'h00, 16'h0006, okr);
      s_valid <= 1'b1;
      repeat (8) begin @(negedge clk); if (s_ready) taken++; @(posedge clk); end
      s_valid <= 1'b0;
      chk(taken, 0, "accepted while stopped");
      $display("test stopped done");
      wc(8'h00, 16'h0007, okr);
      hold <= 1'b1;
      fork
         begin
            repeat (20) @(posedge clk);
            chk(taken, 2, "accepted into full buffer");
            wc(8'h00, 16'h0006, okr);
            hold <= 1'b0;
         end
      join_none
      send(10, 6'h05);
      wf(8'h01);
      chk(len, 64, "padded length");
      chk(fcs, crc(10, 6'h05, 60), "check sequence");
      rc(8'h08, 32'h0000_0005, okr);
      $display("test padded frame done");
      wc(8'h00, 16'h0003, okr);
      slow <= 1'b1;
      send(3, 6'h09);
      wf(8'h02);
      chk(len, 7, "short frame length");
      chk(fcs, crc(3, 6'h09, 3), "short check sequence");
      rc(8'h08, 32'h0000_0009, okr);
      slow <= 1'b0;
      $display("test short frame done");
      wc(8'h00, 16'h000B, okr);
      thr <= 1'b1;
      repeat (60) @(posedge clk);
      chk(frames, 2, "pause without global enable");
      thr <= 1'b0;
      wc(8'h40, 16'h0020, okr);
      thr <= 1'b1;
      wf(8'h03);
      chk(len, 64, "pause length");
      chk(first, 1, "pause destination");
      rc(8'h08, 32'h0000_0009, okr);
      $display("test pause done");
      wc(8'h18, 16'h0001, okr);
      chk(soft_reset_active, 1, "soft reset on");
      rc(8'h00, 32'h0000_0000, okr);
      rc(8'h40, 32'h0000_0000, okr);
      rc(8'h08, 32'h0000_0000, okr);
      rc(8'h18, 32'h0000_0001, okr);
      wc(8'h18, 16'h0000, okr);
      chk(soft_reset_active, 0, "soft reset off");
      $display("test soft reset done");
      complete_run();
   end
endmodule // test_host_port_tx_control
bind hptx_host_port_tx_control hptx_props props (.clk, .srst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_ready, .m_data, .m_last,
   .m_valid, .m_ready, .soft_reset_active);
